/* design/dgm_gpio_route.v */
/*
 GPIO routing for a dual-port deserializer hub: seven pins with output
 source and function selects, forward GPIO routing, device and transmit
 status outputs, and back-channel slot sampling once per back frame.
 Assumes classic Wishbone from a single 250 MHz clock, synchronous reset.
*/
`include "dgm_map.vh"
`timescale 1ns/1ps
module dgm_gpio_route (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [9:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Pins
  input wire [6:0] i_pin,
  output reg [6:0] o_pin,
  output reg [6:0] o_pin_oe,
  // Receive port status
  input wire [1:0] i_rx_lock,
  input wire [1:0] i_rx_pass,
  input wire [1:0] i_rx_frame_valid,
  input wire [1:0] i_rx_line_valid,
  input wire [1:0] i_fwd_frame_strobe,
  input wire [7:0] i_fwd_remote_gpio,
  // Device signals
  input wire i_frame_sync_internal,
  input wire i_frame_sync_external,
  input wire i_device_irq,
  input wire i_csi_irq,
  input wire i_csi_frame_valid,
  input wire i_csi_line_valid,
  input wire i_rx_ports_synced,
  // Back channel
  output reg [7:0] o_back_gpio,
  output reg o_back_frame
);

  reg [7:0] pin_ctl [0:6];
  reg [15:0] port_cfg;
  reg fsync_use_external;
  reg [7:0] bc_low;
  reg [7:0] bc_high;
  reg [7:0] bc_count;
  reg [1:0] pass_select;
  wire [3:0] fwd_gpio [0:1];
  wire frame_sync;
  wire [1:0] rx_en;
  wire wb_req;
  wire [9:0] wb_pin_idx;
  reg [31:0] next_wb_dat;
  integer k;

  ////////////////////////////////////////////////////////////////////////////
  // Per-port signal by function code: remote GPIO, lock, pass, FV, LV
  function port_fn;
    input [2:0] fn;
    input [3:0] gp;
    input lock;
    input pass;
    input fv;
    input lv;
    begin
      case (fn)
        `DGM_FN_4: port_fn = lock;
        `DGM_FN_5: port_fn = pass;
        `DGM_FN_6: port_fn = fv;
        `DGM_FN_7: port_fn = lv;
        default: port_fn = gp[fn[1:0]];
      endcase
    end
  endfunction

  // Back-channel slot value from a 4-bit select
  function slot_value;
    input [3:0] sel;
    input [6:0] pins;
    input fs;
    begin
      if (sel == `DGM_BC_SEL_FSYNC)
        slot_value = fs;
      else if (sel < 4'h7)
        slot_value = pins[sel[2:0]];
      else
        slot_value = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Forward channel holders, one per receive port
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_fwd
      dgm_fwd_port u_fwd (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_linked_count(port_cfg[8*p + `DGM_CFG_CNT_LSB +: 3]),
        .i_parallel_partner(port_cfg[8*p + `DGM_CFG_PARALLEL_BIT]),
        .i_frame_strobe(i_fwd_frame_strobe[p]),
        .i_remote_gpio(i_fwd_remote_gpio[4*p +: 4]),
        .o_gpio(fwd_gpio[p])
      );
    end
  endgenerate

  assign rx_en = {port_cfg[8 + `DGM_CFG_RX_EN_BIT], port_cfg[`DGM_CFG_RX_EN_BIT]};
  assign frame_sync = fsync_use_external ? i_frame_sync_external : i_frame_sync_internal;

  ////////////////////////////////////////////////////////////////////////////
  // Pin output multiplexer
  generate
    for (p = 0; p < 7; p = p + 1) begin : g_pin
      wire [2:0] src;
      wire [2:0] fn;
      wire [1:0] lock_en;
      wire [1:0] pass_sel;
      assign src = pin_ctl[p][`DGM_PIN_SRC_LSB +: 3];
      assign fn = pin_ctl[p][`DGM_PIN_FN_LSB +: 3];
      assign lock_en = i_rx_lock | ~rx_en;
      assign pass_sel = i_rx_pass | ~pass_select;
      always @(posedge i_clock) begin
        if (!i_rst_n) begin
          o_pin[p] <= 1'b0;
          o_pin_oe[p] <= 1'b0;
        end else begin
          o_pin[p] <= 1'b0;
          o_pin_oe[p] <= pin_ctl[p][`DGM_PIN_EN_BIT];
          case (src)
            `DGM_SRC_PORT0: o_pin[p] <= port_fn(fn, fwd_gpio[0], i_rx_lock[0],
              i_rx_pass[0], i_rx_frame_valid[0], i_rx_line_valid[0]);
            `DGM_SRC_PORT1: o_pin[p] <= port_fn(fn, fwd_gpio[1], i_rx_lock[1],
              i_rx_pass[1], i_rx_frame_valid[1], i_rx_line_valid[1]);
            `DGM_SRC_REG: begin
              if (fn == `DGM_FN_0)
                o_pin[p] <= pin_ctl[p][`DGM_PIN_VAL_BIT];
              else
                o_pin_oe[p] <= 1'b0;
            end
            `DGM_SRC_STATUS: begin
              case (fn)
                `DGM_FN_1: o_pin[p] <= |(i_rx_lock & rx_en);
                `DGM_FN_2: o_pin[p] <= (&lock_en) & (|rx_en);
                `DGM_FN_3: o_pin[p] <= &(i_rx_pass | ~rx_en);
                `DGM_FN_4: o_pin[p] <= frame_sync;
                `DGM_FN_5: o_pin[p] <= i_device_irq;
                `DGM_FN_6: o_pin[p] <= ~i_device_irq;
                default: o_pin_oe[p] <= 1'b0;
              endcase
            end
            `DGM_SRC_CSI: begin
              case (fn)
                `DGM_FN_0: o_pin[p] <= &pass_sel;
                `DGM_FN_1: o_pin[p] <= |(i_rx_pass & pass_select);
                `DGM_FN_2: o_pin[p] <= i_csi_frame_valid;
                `DGM_FN_3: o_pin[p] <= i_csi_line_valid;
                `DGM_FN_4: o_pin[p] <= i_rx_ports_synced;
                `DGM_FN_5: o_pin[p] <= i_csi_irq;
                default: o_pin_oe[p] <= 1'b0;
              endcase
            end
            default: o_pin_oe[p] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Back-channel frame timer and slot sampling
  // A pin index past the last pin must read zero, not alias the frame sync code
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      bc_count <= 8'd0;
      o_back_gpio <= 8'h00;
      o_back_frame <= 1'b0;
    end else begin
      o_back_frame <= 1'b0;
      if (bc_count == `DGM_BC_FRAME_CYCLES - 1) begin
        bc_count <= 8'd0;
        o_back_frame <= 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
          o_back_gpio[k] <= slot_value(bc_low[k] ? `DGM_BC_SEL_FSYNC :
            (({1'b0, bc_high[2:0]} + k[3:0]) >= 4'h7) ? `DGM_BC_SEL_ZERO :
            ({1'b0, bc_high[2:0]} + k[3:0]), i_pin, frame_sync);
        end
        for (k = 0; k < 4; k = k + 1) begin
          o_back_gpio[4 + k] <= slot_value(bc_low[4 + k] ? `DGM_BC_SEL_FSYNC :
            (({1'b0, bc_high[6:4]} + k[3:0]) >= 4'h7) ? `DGM_BC_SEL_ZERO :
            ({1'b0, bc_high[6:4]} + k[3:0]), i_pin, frame_sync);
        end
      end else begin
        bc_count <= bc_count + 8'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone register access
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_pin_idx = i_wb_adr >> 2;

  always @* begin
    next_wb_dat = 32'h0000_0000;
    if (i_wb_adr <= `DGM_ADR_PIN_LAST && i_wb_adr[1:0] == 2'b00)
      next_wb_dat = {24'h000000, pin_ctl[wb_pin_idx[2:0]]};
    else if (i_wb_adr == `DGM_ADR_PORT_CFG)
      next_wb_dat = {15'h0000, fsync_use_external, port_cfg};
    else if (i_wb_adr == `DGM_ADR_STATUS)
      next_wb_dat = {9'h000, o_pin_oe, 1'b0, o_pin, 1'b0, i_pin};
    else if (i_wb_adr == `DGM_ADR_PORT_SEL)
      next_wb_dat = {30'h00000000, pass_select};
    else if (i_wb_adr == `DGM_ADR_BC_LOW)
      next_wb_dat = {24'h000000, bc_low};
    else if (i_wb_adr == `DGM_ADR_BC_HIGH)
      next_wb_dat = {24'h000000, bc_high};
  end

  // Writes on the acknowledging cycle; unmapped reads return zero
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      port_cfg <= `DGM_CFG_RESET;
      fsync_use_external <= 1'b0;
      pass_select <= 2'h3;
      bc_low <= 8'h00;
      bc_high <= `DGM_BC_RESET;
      for (k = 0; k < 7; k = k + 1)
        pin_ctl[k] <= `DGM_PIN_RESET;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req)
        o_wb_dat <= next_wb_dat;
      if (wb_req && i_wb_we && i_wb_sel[0]) begin
        if (i_wb_adr <= `DGM_ADR_PIN_LAST && i_wb_adr[1:0] == 2'b00)
          pin_ctl[wb_pin_idx[2:0]] <= i_wb_dat[7:0];
        else if (i_wb_adr == `DGM_ADR_PORT_CFG)
          port_cfg[7:0] <= i_wb_dat[7:0];
        else if (i_wb_adr == `DGM_ADR_PORT_SEL)
          pass_select <= i_wb_dat[1:0];
        else if (i_wb_adr == `DGM_ADR_BC_LOW)
          bc_low <= i_wb_dat[7:0];
        else if (i_wb_adr == `DGM_ADR_BC_HIGH)
          bc_high <= i_wb_dat[7:0];
      end
      if (wb_req && i_wb_we && i_wb_sel[1] && i_wb_adr == `DGM_ADR_PORT_CFG)
        port_cfg[15:8] <= i_wb_dat[15:8];
      if (wb_req && i_wb_we && i_wb_sel[2] && i_wb_adr == `DGM_ADR_PORT_CFG)
        fsync_use_external <= i_wb_dat[16];
    end
  end

endmodule

/* design/dgm_map.vh */
/*
 Constants for the deserializer GPIO routing block: register offsets,
 field positions, reset values, source and function codes, timing counts.
 Assumes a 250 MHz core clock and a 32-bit classic Wishbone register bus.
*/
// Contract
// - Status source: 001 OR lock, 010 AND lock
// - Status source can drive AND of lock
// - Status function 100 drives frame sync
// - Status 101 interrupt high, 110 low, 111 reserved
// - Transmit source: 000 AND pass, 001 OR pass
// - Transmit 010 frame valid, 011 line valid
// - Transmit 100 shows ports 0 and 1 synchronised
// - Transmit 101 interrupt high; other codes reserved
// - Seven pins, each able to output forward data
// - Four forward GPIO values per receive port
// - Any forward value routes to any pin
// - Parallel video serializer gives no forward GPIO
// - Forward update every 1, 2 or 5 frames
// - Any pin can output frame sync or controls
// - All pins start as inputs
// - Four back slots per port, any pin each; code gives slot k the pin at the bc_high base plus k
// - One pin may feed several back slots
// - Back frame is 30 bits long
// - Back slots sampled once per back frame
// - Frame sync selectable as any back slot
// - Back mapping through registers 0x6e and 0x6f
// - Sources 000/001 give port GPIO and status
// - Function 000 register option drives fixed level
`ifndef DGM_MAP_VH
`define DGM_MAP_VH

// Register byte addresses (word index times four)
`define DGM_IDX_BC_LOW 8'h6e
`define DGM_IDX_BC_HIGH 8'h6f
`define DGM_ADR_BC_LOW 10'h1b8
`define DGM_ADR_BC_HIGH 10'h1bc
`define DGM_ADR_PIN0 10'h000
`define DGM_ADR_PIN_LAST 10'h018
`define DGM_ADR_PORT_CFG 10'h020
`define DGM_ADR_STATUS 10'h024
`define DGM_ADR_PORT_SEL 10'h028

// Pin control register fields
`define DGM_PIN_EN_BIT 0
`define DGM_PIN_VAL_BIT 1
`define DGM_PIN_FN_LSB 2
`define DGM_PIN_SRC_LSB 5
`define DGM_PIN_RESET 8'h00

// Port configuration fields per port byte
`define DGM_CFG_CNT_LSB 0
`define DGM_CFG_PARALLEL_BIT 3
`define DGM_CFG_RX_EN_BIT 4
`define DGM_CFG_RESET 16'h1010

// Back-channel slot select codes (4 bits per slot)
`define DGM_BC_SEL_FSYNC 4'h7
`define DGM_BC_SEL_ZERO 4'hf
`define DGM_BC_RESET 8'hff

// Output source codes
`define DGM_SRC_PORT0 3'h0
`define DGM_SRC_PORT1 3'h1
`define DGM_SRC_REG 3'h3
`define DGM_SRC_STATUS 3'h4
`define DGM_SRC_CSI 3'h5

// Function codes
`define DGM_FN_0 3'h0
`define DGM_FN_1 3'h1
`define DGM_FN_2 3'h2
`define DGM_FN_3 3'h3
`define DGM_FN_4 3'h4
`define DGM_FN_5 3'h5
`define DGM_FN_6 3'h6
`define DGM_FN_7 3'h7

// Back frame timing
`define DGM_BC_FRAME_BITS 30
`define DGM_BC_BIT_NS 20
`define DGM_CLK_NS 4
`define DGM_BC_FRAME_CYCLES (`DGM_BC_FRAME_BITS * `DGM_BC_BIT_NS / `DGM_CLK_NS)

// Forward frame spacing by linked count
`define DGM_FWD_SPAN_1 3'd1
`define DGM_FWD_SPAN_2 3'd2
`define DGM_FWD_SPAN_4 3'd5

`endif

/* design/dgm_fwd_port.v */
/*
 Forward-channel GPIO holder for one receive port: latches remote GPIO
 values from the forward frames at the spacing set by the linked count.
 Assumes frame strobes and remote values are synchronous to i_clock.
*/
`include "dgm_map.vh"
`timescale 1ns/1ps
module dgm_fwd_port (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Configuration
  input wire [2:0] i_linked_count,
  input wire i_parallel_partner,
  // Forward link
  input wire i_frame_strobe,
  input wire [3:0] i_remote_gpio,
  // Held values
  output reg [3:0] o_gpio
);

  reg [2:0] frame_count;
  wire [2:0] span;
  wire [3:0] link_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Spacing of updates and lanes in use
  assign span = (i_linked_count <= 3'd1) ? `DGM_FWD_SPAN_1 :
                (i_linked_count == 3'd2) ? `DGM_FWD_SPAN_2 : `DGM_FWD_SPAN_4;
  assign link_mask = (i_linked_count >= 3'd4) ? 4'hf :
                     ((4'h1 << i_linked_count[1:0]) - 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Count forward frames and latch on the last of each span
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      frame_count <= 3'd0;
      o_gpio <= 4'h0;
    end else if (i_parallel_partner || i_linked_count == 3'd0) begin
      frame_count <= 3'd0;
      o_gpio <= 4'h0;
    end else if (i_frame_strobe) begin
      if (frame_count + 3'd1 >= span) begin
        frame_count <= 3'd0;
        o_gpio <= i_remote_gpio & link_mask;
      end else begin
        frame_count <= frame_count + 3'd1;
      end
    end
  end

endmodule

/* tb/dgm_route_sva.sv */
/* Checker for the GPIO routing block: bus answers, pin enables, back frames.
 Bound to the routing block and sees its ports only. */
`timescale 1ns/1ps
module dgm_route_sva (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Watched ports
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire [6:0] o_pin_oe,
  input wire [7:0] o_back_gpio,
  input wire o_back_frame
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  reg [8:0] gap;
  reg seen;
  // Cycles since the last back frame, and whether one was seen yet
  always @(posedge i_clock) begin
    gap <= (!i_rst_n || o_back_frame) ? 9'h000 : gap + 9'h001;
    seen <= i_rst_n && (seen || o_back_frame);
  end
  AST_ACK_ONE: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  AST_IDLE_START: assert property ($rose(i_rst_n) |-> o_pin_oe == 7'h00 && !o_back_frame)
    else $error("pins driven after reset");
  AST_OE_CAUSE: assert property ($changed(o_pin_oe) |-> $past(o_wb_ack))
    else $error("enable moved without write");
  AST_BACK_SPAN: assert property (seen && o_back_frame |-> gap == 9'h095)
    else $error("back frame spacing");
  AST_BACK_LATE: assert property (gap <= 9'h0a0)
    else $error("back frame missing");
  AST_BACK_HOLD: assert property (!o_back_frame |-> $stable(o_back_gpio))
    else $error("back slots moved");
endmodule
bind dgm_gpio_route dgm_route_sva dgm_route_sva_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_pin_oe(o_pin_oe), .o_back_gpio(o_back_gpio),
  .o_back_frame(o_back_frame));

/* tb/dgm_remote_model.sv */
/* Remote serializer model: a forward frame every four cycles on both ports.
 Takes wanted remote levels from the bench; shares the block's clock. */
`timescale 1ns/1ps
module dgm_remote_model (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Wanted remote levels
  input wire [7:0] i_level,
  // Forward link
  output reg [1:0] o_strobe,
  output reg [7:0] o_gpio
);
  reg [1:0] cnt;
  // Values move only at a frame, in the same cycle as the strobe the block latches on
  always @(posedge i_clock) begin
    cnt <= i_rst_n ? cnt + 2'h1 : 2'h0;
    o_strobe <= {2{i_rst_n && cnt == 2'h3}};
    o_gpio <= i_rst_n ? (cnt == 2'h3 ? i_level : o_gpio) : 8'h00;
  end
endmodule

/* tb/tb_dgm_gpio_route.sv */
/* Bench for the GPIO routing block: registers, pin selects, back slots.
 Needs the remote model and the checker compiled first. */
`include "dgm_map.vh"
`timescale 1ns/1ps
module tb_dgm_gpio_route;
  reg i_clock = 1'b0, i_rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg fsi = 1'b0, fse = 1'b0, dirq = 1'b0, cirq = 1'b1, cfv = 1'b1, clv = 1'b0, syn = 1'b1;
  reg [1:0] lock = 2'h0, pass = 2'h1, fv = 2'h2, lv = 2'h0;
  reg [6:0] drv = 7'h00;
  reg [7:0] lvl = 8'h00;
  reg [9:0] adr = 10'h000;
  reg [31:0] wd = 32'h0, rd;
  wire [31:0] dat;
  wire ack, bfr;
  wire [6:0] po, oe, pw;
  wire [7:0] bgp, rgp;
  wire [1:0] fst;
  integer error_cnt = 0, n_checks = 0, cycles = 0;
  // Pad level: the block wins where it drives
  assign pw = (oe & po) | (~oe & drv);
  dgm_gpio_route dgm_gpio_route_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wd), .o_wb_dat(dat), .o_wb_ack(ack),
    .i_pin(pw), .o_pin(po), .o_pin_oe(oe), .i_rx_lock(lock), .i_rx_pass(pass), .i_rx_frame_valid(fv),
    .i_rx_line_valid(lv), .i_fwd_frame_strobe(fst), .i_fwd_remote_gpio(rgp), .i_frame_sync_internal(fsi),
    .i_frame_sync_external(fse), .i_device_irq(dirq), .i_csi_irq(cirq), .i_csi_frame_valid(cfv),
    .i_csi_line_valid(clv), .i_rx_ports_synced(syn), .o_back_gpio(bgp), .o_back_frame(bfr));
  dgm_remote_model dgm_remote_model_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_level(lvl),
    .o_strobe(fst), .o_gpio(rgp));
  ////////////////////////////////////////
  // Clock
  initial begin
    forever #2 i_clock = ~i_clock;
  end
  // Hang guard
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] s, input [31:0] x, g);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s expected %h seen %h", s, x, g);
      end
    end
  endtask
  task rst;
    begin
      @(posedge i_clock);
      i_rst_n <= 1'b0;
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
    end
  endtask
  // Classic single cycle; held until ack is seen at an edge
  task wb(input [31:0] w, a, d);
    integer k;
    begin
      @(posedge i_clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w[0];
      adr <= a[9:0];
      wd <= d;
      for (k = 0; k < 20 && ack !== 1'b1; k = k + 1) @(posedge i_clock);
      if (ack !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED ack expected 1 seen %b", ack);
      end
      rd = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // Program pin n with control byte c, then judge enable and level
  task pin(input [31:0] n, c, xoe, xv);
    begin
      wb(1, n * 4, c);
      repeat (2) @(posedge i_clock);
      #1;
      chk("oe", xoe, oe[n]);
      if (xoe) chk("pin", xv, po[n]);
    end
  endtask
  task frm;
    integer k, f;
    begin
      f = 0;
      for (k = 0; k < 400 && f < 2; k = k + 1) begin
        @(posedge i_clock);
        f = f + (bfr === 1'b1);
      end
      #1;
    end
  endtask
  ////////////////////////////////////////
  task t_regs;
    begin
      wb(0, `DGM_ADR_PIN0, 0);
      chk("pin0", 0, rd);
      wb(0, `DGM_ADR_BC_HIGH, 0);
      chk("bchi", 'hff, rd);
      wb(1, `DGM_ADR_BC_LOW, 'h5a);
      wb(0, `DGM_ADR_BC_LOW, 0);
      chk("bclo", 'h5a, rd);
      wb(1, 'h3fc, 'hff);
      wb(0, 'h3fc, 0);
      chk("unmap", 0, rd);
    end
  endtask
  task t_status;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        lock <= k[1:0];
        pin(1, 'h85, 1, |k[1:0]);
        pin(1, 'h89, 1, &k[1:0]);
      end
      fsi <= 1'b1;
      dirq <= 1'b1;
      pin(1, 'h91, 1, 1);
      pin(1, 'h95, 1, 1);
      pin(1, 'h99, 1, 0);
      pin(1, 'h9d, 0, 0);
    end
  endtask
  task t_csi;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) pin(2, 'ha1 + k * 4, k < 6, 6'h36 >> k & 1);
      pin(2, 'h41, 0, 0);
      pin(2, 'hc1, 0, 0);
      pin(2, 'he1, 0, 0);
      pin(3, 'h63, 1, 1);
      pin(3, 'h61, 1, 0);
      pin(3, 'h62, 0, 0);
      pin(3, 'h67, 0, 0);
    end
  endtask
  task t_fwd;
    integer k;
    begin
      wb(1, `DGM_ADR_PORT_CFG, 'h1414);
      lvl <= 8'ha5;
      lock <= 2'h2;
      repeat (48) @(posedge i_clock);
      for (k = 0; k < 8; k = k + 1) pin(k % 4 + k / 4 * 3, k / 4 * 32 + k % 4 * 4 + 1, 1, lvl[k]);
      for (k = 4; k < 8; k = k + 1) pin(0, 33 + k * 4, 1, !k[0]);
      wb(1, `DGM_ADR_PORT_CFG, 'h1119);
      repeat (12) @(posedge i_clock);
      pin(1, 1, 1, 0);
    end
  endtask
  task t_back;
    begin
      wb(1, `DGM_ADR_BC_HIGH, 'h20);
      drv <= 7'h2c;
      frm;
      chk("back", 'hbc, bgp);
      wb(1, `DGM_ADR_BC_LOW, 'h41);
      fsi <= 1'b1;
      frm;
      chk("fsync", 'hfd, bgp);
    end
  endtask
  // Main sequence
  initial begin
    rst;
    chk("oe0", 0, oe);
    t_regs;
    t_status;
    t_csi;
    t_fwd;
    rst;
    t_back;
    stop_test;
  end
endmodule
